// File: include/pecp_pkg.sv
// constants for the pci endian, clock-speed and power-management block
package pecp_pkg;
  localparam int unsigned NUM_WIN = 4;          // three memory windows plus one io window
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3HOT = 2'h3;
  localparam logic [1:0] DIV_SEL_33 = 2'h0;    // divider code for 33 MHz
  localparam logic [1:0] DIV_SEL_66 = 2'h1;    // divider code for 66 MHz
  localparam logic [1:0] DIV_SEL_RESET = 2'h0;
  typedef enum logic [1:0] {PM_D0_UNINIT, PM_D0_ACTIVE, PM_D3HOT, PM_OTHER} pm_state_t;
endpackage

// File: logic/pci_endian_clock_power.sv
// pci byte-swap paths, fast-bus clock setup and power-management event logic
//
// Functional notes
// - each window with swap enabled (inbound also needs prefetch enabled) reverses the four bytes of every 32-bit word.
// - swap disabled by default keeps every byte at its own address.
// - big-endian system with swap keeps pci byte order for 32-bit accesses.
// - outbound window swap comes from its local base register swap bit.
// - inbound window swap comes from its local base register swap bit.
// - inbound swapping is forced off when the window has prefetch disabled.
// - fast mode bit during soft reset drives the fast-drive signal asserted.
// - divider field change moves generated pci clock from 33 to 66 MHz.
// - satellite mode reads the fast-drive pin into a status bit.
// - states D0 to D3; reset or D3hot exit gives uninitialised D0.
// - host writing 11b sets the state change flag and enters D3hot.
// - the current power-state field is mirrored for local software.
// - wake enable allows wake pin, sets a flag and is mirrored.
// - local wake request sets wake status and pulls the wake pin low.
// - host writing 1 clears wake status, releases pin, sets cleared flag.
// - host mode sets the detected flag when a satellite pulls the wake pin.
`timescale 1ns/10ps
module pci_endian_clock_power
  import pecp_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic controller_hard_reset_i,
  // mode
  input wire logic host_mode_i,
  // outbound data path (local to pci)
  input wire logic [31:0] out_data_i,
  input wire logic [1:0] out_win_i,
  input wire logic [NUM_WIN-1:0] outbound_window_byte_swap_i,
  output logic [31:0] out_data_o,
  // inbound data path (pci to local)
  input wire logic [31:0] in_data_i,
  input wire logic [1:0] in_win_i,
  input wire logic [NUM_WIN-1:0] inbound_window_byte_swap_i,
  input wire logic [NUM_WIN-1:0] inbound_prefetch_en_i,
  output logic [31:0] in_data_o,
  // clock speed setup
  input wire logic controller_soft_reset_i,
  input wire logic chip_fast_pci_mode_i,
  input wire logic [1:0] pci_clock_divider_sel_i,
  input wire logic fast_drive_in_i,
  output logic fast_drive_out_o,
  output logic fast_drive_oe_n_o,
  output logic [1:0] pci_clock_div_o,
  output logic fast_drive_input_status_o,
  // power state, host side config writes
  input wire logic sw_init_done_i,
  input wire logic pm_state_wr_i,
  input wire logic [1:0] pm_state_wdata_i,
  input wire logic wake_enable_wr_i,
  input wire logic wake_enable_wdata_i,
  input wire logic wake_status_clr_wr_i,
  // local software controls
  input wire logic wake_request_bit_i,
  input wire logic [3:0] flag_clear_i,
  input wire logic [3:0] irq_enable_i,
  // wake pin, open drain
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe_n_o,
  // status
  output logic [1:0] satellite_power_state_mirror_o,
  output logic pm_active_o,
  output logic wake_enable_mirror_o,
  output logic wake_status_o,
  output logic power_state_change_flag_o,
  output logic wake_enable_set_flag_o,
  output logic wake_status_cleared_flag_o,
  output logic wake_detected_flag_o,
  output logic pm_irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // byte swap paths
  logic [31:0] out_data_d, out_data_q, in_data_d, in_data_q;
  logic out_swap, in_swap;

  // reversing bytes keeps pci order for 32-bit words from a big-endian core
  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  always_comb
  begin
    out_swap = outbound_window_byte_swap_i[out_win_i];
    in_swap = inbound_window_byte_swap_i[in_win_i] & inbound_prefetch_en_i[in_win_i];
    out_data_d = out_swap ? swap32(out_data_i) : out_data_i;
    in_data_d = in_swap ? swap32(in_data_i) : in_data_i;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_data_q <= 32'h0;
      in_data_q <= 32'h0;
    end
    else if (clk_en_i)
    begin
      out_data_q <= out_data_d;
      in_data_q <= in_data_d;
    end
  end

  assign out_data_o = out_data_q;
  assign in_data_o = in_data_q;

  ////////////////////////////////////////////////////////////////////////
  // fast bus setup; the latch only moves during soft reset so the pin never
  // changes while the bus is live
  logic fast_d, fast_q, fstat_d, fstat_q, fast_oe_n_d, fast_oe_n_q;
  logic [1:0] div_d, div_q;

  always_comb
  begin
    fast_d = fast_q;
    if (controller_soft_reset_i)
      fast_d = chip_fast_pci_mode_i;
    div_d = pci_clock_divider_sel_i;
    fstat_d = host_mode_i ? fast_q : fast_drive_in_i;
    // host drives the pin, satellite only listens
    fast_oe_n_d = ~host_mode_i;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fast_q <= 1'h0;
      div_q <= DIV_SEL_RESET;
      fstat_q <= 1'h0;
      fast_oe_n_q <= 1'h1;
    end
    else if (clk_en_i)
    begin
      fast_q <= fast_d;
      div_q <= div_d;
      fstat_q <= fstat_d;
      fast_oe_n_q <= fast_oe_n_d;
    end
  end

  // pins and status come straight from their flops
  assign fast_drive_out_o = fast_q;
  assign fast_drive_oe_n_o = fast_oe_n_q;
  assign pci_clock_div_o = div_q;
  assign fast_drive_input_status_o = fstat_q;

  ////////////////////////////////////////////////////////////////////////
  // power state and wake event logic
  pm_state_t pm_d, pm_q;
  logic [1:0] ps_d, ps_q;
  logic wen_d, wen_q, wst_d, wst_q;
  logic [3:0] flg_d, flg_q, ev;
  logic irq_d, irq_q, wpin_d, wpin_q, act_d, act_q;
  logic soft_rst;

  assign soft_rst = controller_hard_reset_i;

  // flag order: 0 state change, 1 wake enable set, 2 wake cleared, 3 detected
  always_comb
  begin
    pm_d = pm_q;
    ps_d = ps_q;
    wen_d = wen_q;
    wst_d = wst_q;
    ev = 4'h0;
    case (pm_q)
      PM_D0_UNINIT: if (sw_init_done_i) pm_d = PM_D0_ACTIVE;
      PM_D0_ACTIVE, PM_OTHER, PM_D3HOT: ;
      default: pm_d = PM_D0_UNINIT;
    endcase
    if (!host_mode_i && pm_state_wr_i)
    begin
      ps_d = pm_state_wdata_i;
      if (pm_state_wdata_i == PS_D3HOT)
      begin
        pm_d = PM_D3HOT;
        ev[0] = 1'h1;
      end
      else if (pm_q == PM_D3HOT && pm_state_wdata_i == PS_D0)
        pm_d = PM_D0_UNINIT;
      else if (pm_state_wdata_i != PS_D0)
        pm_d = PM_OTHER;
      else if (pm_q == PM_OTHER)
        pm_d = PM_D0_ACTIVE; // light sleep keeps its setup, so D0 comes back active
    end
    if (!host_mode_i && wake_enable_wr_i)
    begin
      wen_d = wake_enable_wdata_i;
      ev[1] = wake_enable_wdata_i & ~wen_q;
    end
    // a same-cycle local request keeps the status set, so no cleared flag then
    if (!host_mode_i && wake_status_clr_wr_i && wst_q && !wake_request_bit_i)
    begin
      wst_d = 1'h0;
      ev[2] = 1'h1;
    end
    if (!host_mode_i && wake_request_bit_i)
      wst_d = 1'h1;
    ev[3] = host_mode_i & ~wake_pin_i;
    // set beats clear so no event is lost
    flg_d = (flg_q & ~flag_clear_i) | ev;
    // the hard reset bit returns all power state to its power-on values
    if (soft_rst)
    begin
      pm_d = PM_D0_UNINIT;
      ps_d = PS_D0;
      wen_d = 1'h0;
      wst_d = 1'h0;
      flg_d = 4'h0;
    end
    irq_d = |(flg_d & irq_enable_i);
    // the enable is kept inverted so the pin enable leaves a flop untouched
    wpin_d = ~(~host_mode_i & wst_d & wen_d);
    act_d = (pm_d == PM_D0_ACTIVE);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pm_q <= PM_D0_UNINIT;
      ps_q <= PS_D0;
      wen_q <= 1'h0;
      wst_q <= 1'h0;
      flg_q <= 4'h0;
      irq_q <= 1'h0;
      wpin_q <= 1'h1;
      act_q <= 1'h0;
    end
    else if (clk_en_i)
    begin
      pm_q <= pm_d;
      ps_q <= ps_d;
      wen_q <= wen_d;
      wst_q <= wst_d;
      flg_q <= flg_d;
      irq_q <= irq_d;
      wpin_q <= wpin_d;
      act_q <= act_d;
    end
  end

  // open drain: only ever drive low, the enable does the signalling
  assign wake_pin_o = 1'h0;
  assign wake_pin_oe_n_o = wpin_q;
  assign satellite_power_state_mirror_o = ps_q;
  assign pm_active_o = act_q;
  assign wake_enable_mirror_o = wen_q;
  assign wake_status_o = wst_q;
  assign power_state_change_flag_o = flg_q[0];
  assign wake_enable_set_flag_o = flg_q[1];
  assign wake_status_cleared_flag_o = flg_q[2];
  assign wake_detected_flag_o = flg_q[3];
  assign pm_irq_o = irq_q;

endmodule

// File: tb/pecp_props.sv
// assertions on the ports of the pci endian, clock and power block
`timescale 1ns/10ps
module pecp_props
  import pecp_pkg::*;
(
  // clock, reset, mode
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic host_mode_i,
  input wire logic controller_hard_reset_i,
  // outbound path
  input wire logic [31:0] out_data_i,
  input wire logic [1:0] out_win_i,
  input wire logic [NUM_WIN-1:0] outbound_window_byte_swap_i,
  input wire logic [31:0] out_data_o,
  // wake handshake
  input wire logic wake_request_bit_i,
  input wire logic wake_enable_wr_i,
  input wire logic wake_status_clr_wr_i,
  input wire logic wake_pin_i,
  input wire logic [3:0] flag_clear_i,
  input wire logic wake_status_o,
  input wire logic wake_pin_oe_n_o,
  input wire logic wake_enable_mirror_o,
  input wire logic wake_status_cleared_flag_o,
  input wire logic wake_detected_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  // frozen cycles hold all state, so they are not judged
  default disable iff (reset_i || !clk_en_i);
  wire logic sat = !host_mode_i && !controller_hard_reset_i;
  wire logic [31:0] rev = {out_data_i[7:0], out_data_i[15:8], out_data_i[23:16], out_data_i[31:24]};
  // wake steps: request with enable, then host clear
  sequence req_s; sat && wake_request_bit_i && wake_enable_mirror_o && !wake_enable_wr_i; endsequence
  sequence clr_s; sat && wake_status_o && wake_status_clr_wr_i && !wake_request_bit_i; endsequence
  swap_out_a:
    assert property (outbound_window_byte_swap_i[out_win_i] |=> out_data_o == $past(rev)) else $error("no swap");
  keep_out_a:
    assert property (!outbound_window_byte_swap_i[out_win_i] |=> out_data_o == $past(out_data_i)) else $error("moved");
  wake_pull_a:
    assert property (req_s |=> wake_status_o && !wake_pin_oe_n_o) else $error("no pull");
  wake_rel_a:
    assert property (clr_s |=> !wake_status_o && wake_pin_oe_n_o && wake_status_cleared_flag_o) else $error("no release");
  pin_cause_a:
    assert property (!wake_pin_oe_n_o |-> wake_status_o && wake_enable_mirror_o) else $error("stray pull");
  detect_set_a:
    assert property (host_mode_i && $fell(wake_pin_i) && !controller_hard_reset_i |=> wake_detected_flag_o)
      else $error("no detect");
  detect_hold_a:
    assert property (wake_detected_flag_o && !flag_clear_i[3] && !controller_hard_reset_i |=> wake_detected_flag_o)
      else $error("detect lost");
  clr_hold_a:
    assert property (wake_status_cleared_flag_o && !flag_clear_i[2] && !controller_hard_reset_i |=>
      wake_status_cleared_flag_o) else $error("clear flag lost");
endmodule
bind pci_endian_clock_power pecp_props props (.*);

// File: tb/pci_far_agent.sv
// far-side agent: open-drain wake line with pull-up, fast-drive pin
`timescale 1ns/10ps
module pci_far_agent
(
  // device pins
  input wire logic wake_od_i,
  input wire logic wake_oe_n_i,
  input wire logic fast_od_i,
  input wire logic fast_oe_n_i,
  // far-side behaviour
  input wire logic sat_pull_i,
  input wire logic m66_level_i,
  output logic wake_line_o,
  output logic fast_line_o
);
  // any puller wins; the pull-up holds the line high otherwise
  assign wake_line_o = (wake_oe_n_i ? 1'h1 : wake_od_i) & !sat_pull_i;
  // the far host drives the pin whenever the device does not
  assign fast_line_o = fast_oe_n_i ? m66_level_i : fast_od_i;
endmodule

// File: tb/tb_top.sv
// bench: byte swap, fast-bus setup and wake events
`timescale 1ns/10ps
module tb_top
  import pecp_pkg::*;
;
  logic sys_clk_i = 1'h0, reset_i = 1'h1, clk_en_i = 1'h1, controller_hard_reset_i = 1'h0, host_mode_i = 1'h0;
  logic controller_soft_reset_i = 1'h0, chip_fast_pci_mode_i = 1'h0, sw_init_done_i = 1'h0, pm_state_wr_i = 1'h0;
  logic wake_enable_wr_i = 1'h0, wake_enable_wdata_i = 1'h0, wake_status_clr_wr_i = 1'h0, wake_request_bit_i = 1'h0;
  logic sat_pull = 1'h0, m66_level = 1'h0;
  logic far_fast_capable = 1'h1;
  logic [1:0] out_win_i = 2'h0, in_win_i = 2'h0, pm_state_wdata_i = 2'h0, pci_clock_divider_sel_i = DIV_SEL_33;
  logic [3:0] outbound_window_byte_swap_i = 4'h5, inbound_window_byte_swap_i = 4'hF, inbound_prefetch_en_i = 4'h3;
  logic [3:0] flag_clear_i = 4'h0, irq_enable_i = 4'h0;
  logic [31:0] out_data_i = 32'h11223344, in_data_i = 32'hA1B2C3D4;
  wire logic fast_drive_in_i, wake_pin_i, fast_drive_out_o, fast_drive_oe_n_o, fast_drive_input_status_o, pm_active_o;
  wire logic wake_pin_o, wake_pin_oe_n_o, wake_enable_mirror_o, wake_status_o, power_state_change_flag_o, pm_irq_o;
  wire logic wake_enable_set_flag_o, wake_status_cleared_flag_o, wake_detected_flag_o;
  wire logic [1:0] pci_clock_div_o, satellite_power_state_mirror_o;
  wire logic [31:0] out_data_o, in_data_o;
  int num_errors = 0, n_checks = 0;
  pci_endian_clock_power dut (.*);
  pci_far_agent far (.wake_od_i(wake_pin_o), .wake_oe_n_i(wake_pin_oe_n_o), .fast_od_i(fast_drive_out_o),
    .fast_oe_n_i(fast_drive_oe_n_o), .sat_pull_i(sat_pull), .m66_level_i(m66_level), .wake_line_o(wake_pin_i),
    .fast_line_o(fast_drive_in_i));
  always #50 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs move at the falling edge, outputs are read at the next falling edge
  task tick;
    @(negedge sys_clk_i);
  endtask
  // every window both ways; inbound prefetch is off on windows 2 and 3
  task t_data;
    for (int w = 0; w < 4; w++)
    begin
      out_win_i = 2'(w);
      in_win_i = 2'(w);
      tick;
      chk(out_data_o, w[0] ? 32'h11223344 : 32'h44332211);
      chk(in_data_o, w[1] ? 32'hA1B2C3D4 : 32'hD4C3B2A1);
    end
    $display("data end");
  endtask
  // speed change under soft reset, then satellite reads the pin
  task t_clock;
    host_mode_i = 1'h1;
    controller_soft_reset_i = 1'h1;
    chip_fast_pci_mode_i = far_fast_capable;
    pci_clock_divider_sel_i = far_fast_capable ? DIV_SEL_66 : DIV_SEL_33;
    repeat (3) tick;
    chk({fast_drive_out_o, fast_drive_oe_n_o, pci_clock_div_o}, {2'h2, DIV_SEL_66});
    controller_soft_reset_i = 1'h0;
    host_mode_i = 1'h0;
    m66_level = 1'h1;
    repeat (2) tick;
    chk(fast_drive_input_status_o, 1'h1);
    m66_level = 1'h0;
    tick;
    chk(fast_drive_input_status_o, 1'h0);
    $display("clock end");
  endtask
  // power states, then a full wake request and host clear
  task t_power;
    chk({pm_active_o, satellite_power_state_mirror_o}, {1'h0, PS_D0});
    sw_init_done_i = 1'h1;
    tick;
    sw_init_done_i = 1'h0;
    chk(pm_active_o, 1'h1);
    irq_enable_i = 4'h4;
    pm_state_wr_i = 1'h1;
    pm_state_wdata_i = PS_D3HOT;
    tick;
    pm_state_wr_i = 1'h0;
    wake_enable_wr_i = 1'h1;
    wake_enable_wdata_i = 1'h1;
    chk({power_state_change_flag_o, pm_irq_o, satellite_power_state_mirror_o, pm_active_o}, {2'h2, PS_D3HOT, 1'h0});
    tick;
    wake_enable_wr_i = 1'h0;
    wake_request_bit_i = 1'h1;
    chk({wake_enable_mirror_o, wake_enable_set_flag_o}, 2'h3);
    tick;
    wake_request_bit_i = 1'h0;
    wake_status_clr_wr_i = 1'h1;
    chk({wake_status_o, wake_pin_i, wake_pin_o, wake_pin_oe_n_o}, 4'h8);
    tick;
    wake_status_clr_wr_i = 1'h0;
    chk({wake_status_o, wake_pin_i, wake_status_cleared_flag_o, pm_irq_o}, 4'h7);
    // leaving D3hot gives uninitialised D0; local clear drops the flag and its interrupt
    pm_state_wr_i = 1'h1;
    pm_state_wdata_i = PS_D0;
    flag_clear_i = 4'h4;
    tick;
    pm_state_wr_i = 1'h0;
    flag_clear_i = 4'h0;
    chk({pm_active_o, satellite_power_state_mirror_o, wake_status_cleared_flag_o, pm_irq_o}, {1'h0, PS_D0, 2'h0});
    sw_init_done_i = 1'h1;
    tick;
    sw_init_done_i = 1'h0;
    chk(pm_active_o, 1'h1);
    $display("power end");
  endtask
  // host sees a satellite pull; flag holds until hard reset
  task t_detect;
    host_mode_i = 1'h1;
    tick;
    chk(wake_detected_flag_o, 1'h0);
    sat_pull = 1'h1;
    tick;
    sat_pull = 1'h0;
    tick;
    chk(wake_detected_flag_o, 1'h1);
    controller_hard_reset_i = 1'h1;
    tick;
    controller_hard_reset_i = 1'h0;
    chk(wake_detected_flag_o, 1'h0);
    $display("detect end");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) tick;
    reset_i = 1'h0;
    tick;
    t_data;
    t_clock;
    t_power;
    t_detect;
    summarize;
  end
endmodule
